//--- core/lds_supervisor.sv
// Added by the designer: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
// Behaviour
// - the timing-select voltage picks one of seventeen options fixing integrator time constant, minimum frequency and dead-time ceiling.
// - two voltage bands serve the two current thresholds, and a voltage below 0.392 V or above 4.589 V is invalid.
// - the feedback clamp current is on only while the feedback pin is below its clamp threshold.
// - only the high-to-low dead time is measured by the slew detector and is reused for the low-to-high edge.
// - with no slew signal last high-to-low edge or a zero-current event last cycle, the low-to-high dead time ends on current polarity.
// - in burst mode, during zero-current prevention or with slow slew, current polarity also ends the high-to-low dead time.
// - input sense below the brown-out stop level stops switching and turns on the hysteresis sink for the brown-out state.
// - input sense above brown-in leaves brown-out straight into soft start without the fault idle delay.
// - with input over-voltage enabled, input sense above the over-voltage level stops switching into the fault state.
// - after the idle time an input over-voltage fault restarts if cleared, otherwise stays off until it clears.
// - output over-voltage is declared only after the protection pin stays high for 40 us without a break.
// - the protection pin below the over-temperature level enters the fault state.
// - after 1 s of over-temperature fault, restart if the protection pin is above the over-voltage level, else keep waiting.
// - over-temperature detection is off during burst mode and back on with normal switching.
// - the fault idle time before any retry is one second from fault entry.
module lds_supervisor #(
  parameter int FAULT_IDLE_CYCLES = lds_pkg::FAULT_IDLE_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [12:0] tsetMv,
  input wire logic tsetValid,
  input wire logic ocpHighBand,
  input wire lds_pkg::lds_cmp_type cmpIn,
  input wire logic burstMode,
  input wire logic zcsAction,
  input wire logic zcsEvent,
  input wire logic slowSlew,
  input wire logic hoFall,
  input wire logic loFall,
  input wire logic softStartDone,
  output logic switchEn,
  output logic softStartReq,
  output logic hysSinkEn,
  output logic fbClampEn,
  output logic loOnReq,
  output logic hoOnReq,
  output logic [9:0] intTcNs,
  output logic [12:0] minFreqDkhz,
  output logic [7:0] deadTimeMax
);

  function automatic logic [5:0] optDecode(input logic [12:0] mv, input logic hiBand);
    logic [5:0] res;
    logic [12:0] nom;
    res = 6'h00;
    if (mv >= lds_pkg::TIMING_SELECT_PIN_INVALID_LO_MV && mv <= lds_pkg::TIMING_SELECT_PIN_INVALID_HI_MV)
    begin
      for (int i = 0; i < lds_pkg::OPT_COUNT; i++)
      begin
        nom = hiBand ? lds_pkg::TIMING_SELECT_PIN_HI_BAND_MV[i] : lds_pkg::TIMING_SELECT_PIN_LO_BAND_MV[i];
        if (mv + lds_pkg::TIMING_SELECT_PIN_TOL_MV >= nom && mv <= nom + lds_pkg::TIMING_SELECT_PIN_TOL_MV)
          res = {1'b1, 5'(i)};
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  lds_pkg::lds_cmp_type cmpMeta_q;
  lds_pkg::lds_cmp_type cmp_q;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cmpMeta_q <= '0;
      cmp_q <= '0;
    end
    else
    begin
      cmpMeta_q <= cmpIn;
      cmp_q <= cmpMeta_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      fbClampEn <= 1'b0;
    else
      fbClampEn <= cmp_q.fbLow;
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic optLatched_q;
  logic optInvalid_q;
  logic [4:0] optIdx_q;
  logic [5:0] optDec;

  assign optDec = optDecode(tsetMv, ocpHighBand);

  // captured once; later moves of the pin are ignored until power-on reset
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      optLatched_q <= 1'b0;
      optInvalid_q <= 1'b0;
      optIdx_q <= 5'h00;
    end
    else if (tsetValid && !optLatched_q)
    begin
      optLatched_q <= 1'b1;
      optInvalid_q <= !optDec[5];
      optIdx_q <= optDec[4:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      intTcNs <= '0;
      minFreqDkhz <= '0;
      deadTimeMax <= lds_pkg::DT_LONG_CYC;
    end
    else
    begin
      intTcNs <= lds_pkg::INT_TC_NS[optIdx_q];
      minFreqDkhz <= lds_pkg::MIN_FREQ_DKHZ[optIdx_q];
      deadTimeMax <= (optIdx_q >= lds_pkg::OPT_SHORT_DT_FIRST) ? lds_pkg::DT_SHORT_CYC : lds_pkg::DT_LONG_CYC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] ctrl_q;
  logic ack_q;
  lds_pkg::lds_state_type state_q;
  lds_pkg::lds_cause_type cause_q;
  logic [7:0] dtMeas_q;

  // one wait cycle per access keeps read data registered
  assign waitrequest = (read || write) && !ack_q;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ack_q <= 1'b0;
      ctrl_q <= lds_pkg::CTRL_RESET;
      readdata <= '0;
    end
    else
    begin
      ack_q <= (read || write) && !ack_q;
      if (write && ack_q && address == lds_pkg::REG_CTRL)
        ctrl_q <= writedata[1:0];
      if (read && !ack_q)
      begin
        readdata <= '0;
        unique case (address)
          lds_pkg::REG_CTRL: readdata[1:0] <= ctrl_q;
          lds_pkg::REG_STATUS:
          begin
            readdata[lds_pkg::ST_STATE_LSB +: 3] <= state_q;
            readdata[lds_pkg::ST_CAUSE_LSB +: 2] <= cause_q;
            readdata[lds_pkg::ST_OPT_LSB +: 5] <= optIdx_q;
            readdata[lds_pkg::ST_INVALID_BIT] <= optInvalid_q;
            readdata[lds_pkg::ST_LATCHED_BIT] <= optLatched_q;
          end
          lds_pkg::REG_DEADTIME: readdata[7:0] <= dtMeas_q;
          default: readdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic [9:0] ovpCnt_q;
  logic outOvp;

  always_ff @(posedge clk)
  begin
    if (!nrst || !cmp_q.protAboveOvp)
      ovpCnt_q <= '0;
    else if (ovpCnt_q != 10'(lds_pkg::OVP_QUAL_CYC))
      ovpCnt_q <= ovpCnt_q + 10'h001;
  end
  assign outOvp = ovpCnt_q == 10'(lds_pkg::OVP_QUAL_CYC);

  logic [24:0] idleCnt_q;
  logic idleDone;
  logic inOvp;
  logic otpTrip;

  assign idleDone = idleCnt_q >= 25'(FAULT_IDLE_CYCLES - 1);
  assign inOvp = ctrl_q[lds_pkg::CTRL_OVP_EN_BIT] && cmp_q.blkAboveOvp;
  assign otpTrip = cmp_q.protBelowOtp && !burstMode;

  always_ff @(posedge clk)
  begin
    if (!nrst || state_q != lds_pkg::S_FAULT)
      idleCnt_q <= '0;
    else if (!idleDone)
      idleCnt_q <= idleCnt_q + 25'h0000001;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_q <= lds_pkg::S_INIT;
      cause_q <= lds_pkg::C_NONE;
    end
    else
    begin
      unique case (state_q)
        lds_pkg::S_INIT:
          if (optLatched_q)
            state_q <= optInvalid_q ? lds_pkg::S_INHIBIT : lds_pkg::S_BROWN;
        lds_pkg::S_INHIBIT:
          state_q <= lds_pkg::S_INHIBIT;
        lds_pkg::S_BROWN:
          if (cmp_q.blkAboveBrownIn && ctrl_q[lds_pkg::CTRL_RUN_EN_BIT])
            state_q <= lds_pkg::S_SOFT;
        lds_pkg::S_SOFT, lds_pkg::S_RUN:
          if (inOvp)
          begin
            state_q <= lds_pkg::S_FAULT;
            cause_q <= lds_pkg::C_INOVP;
          end
          else if (outOvp)
          begin
            state_q <= lds_pkg::S_FAULT;
            cause_q <= lds_pkg::C_OUTOVP;
          end
          else if (otpTrip)
          begin
            state_q <= lds_pkg::S_FAULT;
            cause_q <= lds_pkg::C_OTP;
          end
          else if (cmp_q.blkBelowStop || !ctrl_q[lds_pkg::CTRL_RUN_EN_BIT])
            state_q <= lds_pkg::S_BROWN;
          else if (state_q == lds_pkg::S_SOFT && softStartDone)
            state_q <= lds_pkg::S_RUN;
        lds_pkg::S_FAULT:
          if (idleDone)
          begin
            unique case (cause_q)
              lds_pkg::C_INOVP: state_q <= cmp_q.blkAboveOvp ? lds_pkg::S_HOLD : lds_pkg::S_SOFT;
              lds_pkg::C_OTP: state_q <= cmp_q.protAboveOvp ? lds_pkg::S_SOFT : lds_pkg::S_HOLD;
              default: state_q <= lds_pkg::S_SOFT;
            endcase
          end
        lds_pkg::S_HOLD:
          if (cause_q == lds_pkg::C_INOVP ? !cmp_q.blkAboveOvp : cmp_q.protAboveOvp)
            state_q <= lds_pkg::S_SOFT;
        default: state_q <= lds_pkg::S_INIT;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      switchEn <= 1'b0;
      softStartReq <= 1'b0;
      hysSinkEn <= 1'b0;
    end
    else
    begin
      switchEn <= state_q == lds_pkg::S_SOFT || state_q == lds_pkg::S_RUN;
      hysSinkEn <= state_q == lds_pkg::S_BROWN;
      // one-cycle pulse as switching resumes, from brown-in or a fault retry alike
      softStartReq <= state_q == lds_pkg::S_SOFT && !switchEn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic hlActive_q;
  logic lhActive_q;
  logic copyOk_q;
  logic slewSeen_q;
  logic zcsSeen_q;
  logic [7:0] dtCnt_q;
  logic augment;
  logic hlEnd;
  logic lhEnd;

  assign augment = burstMode || zcsAction || slowSlew;
  assign hlEnd = hlActive_q && (cmp_q.slewDone || (augment && !cmp_q.ipolPos) || dtCnt_q >= deadTimeMax - 8'h01);
  assign lhEnd = lhActive_q && (copyOk_q ? dtCnt_q >= dtMeas_q - 8'h01 : cmp_q.ipolPos || dtCnt_q >= deadTimeMax - 8'h01);
  assign loOnReq = hlEnd;
  assign hoOnReq = lhEnd;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      hlActive_q <= 1'b0;
      lhActive_q <= 1'b0;
      copyOk_q <= 1'b0;
      slewSeen_q <= 1'b0;
      zcsSeen_q <= 1'b0;
      dtCnt_q <= '0;
      dtMeas_q <= lds_pkg::DT_LONG_CYC;
    end
    else
    begin
      if (zcsEvent)
        zcsSeen_q <= 1'b1;
      if (hoFall)
      begin
        hlActive_q <= 1'b1;
        dtCnt_q <= '0;
        slewSeen_q <= 1'b0;
      end
      else if (hlEnd)
      begin
        hlActive_q <= 1'b0;
        dtMeas_q <= dtCnt_q + 8'h01;
        slewSeen_q <= cmp_q.slewDone;
      end
      else if (loFall)
      begin
        lhActive_q <= 1'b1;
        dtCnt_q <= '0;
        copyOk_q <= slewSeen_q && !zcsSeen_q && !zcsEvent;
        zcsSeen_q <= zcsEvent;
      end
      else if (lhEnd)
        lhActive_q <= 1'b0;
      else if (hlActive_q || lhActive_q)
        dtCnt_q <= dtCnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_clamp;
    @(posedge clk) disable iff (!nrst) $rose(cmp_q.fbLow) |=> fbClampEn ##1 (fbClampEn || !cmp_q.fbLow);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp current not following feedback level");

  property p_brown;
    @(posedge clk) disable iff (!nrst)
      (state_q == lds_pkg::S_RUN && cmp_q.blkBelowStop && !inOvp && !outOvp && !otpTrip)
      |=> state_q == lds_pkg::S_BROWN ##1 hysSinkEn && !switchEn;
  endproperty
  a_brown: assert property (p_brown) else $error("brown-out not entered");

  property p_brownin;
    @(posedge clk) disable iff (!nrst)
      (state_q == lds_pkg::S_BROWN && cmp_q.blkAboveBrownIn && ctrl_q[lds_pkg::CTRL_RUN_EN_BIT])
      |=> state_q == lds_pkg::S_SOFT;
  endproperty
  a_brownin: assert property (p_brownin) else $error("brown-in did not start soft start at once");

  property p_inovp;
    @(posedge clk) disable iff (!nrst)
      (state_q == lds_pkg::S_RUN && inOvp) |=> state_q == lds_pkg::S_FAULT && cause_q == lds_pkg::C_INOVP;
  endproperty
  a_inovp: assert property (p_inovp) else $error("input over-voltage not faulted");

  property p_outovp;
    @(posedge clk) disable iff (!nrst)
      $rose(state_q == lds_pkg::S_FAULT && cause_q == lds_pkg::C_OUTOVP)
      |-> $past(ovpCnt_q) == 10'(lds_pkg::OVP_QUAL_CYC);
  endproperty
  a_outovp: assert property (p_outovp) else $error("output over-voltage declared early");

  property p_otp_burst;
    @(posedge clk) disable iff (!nrst)
      $rose(state_q == lds_pkg::S_FAULT && cause_q == lds_pkg::C_OTP) |-> !$past(burstMode);
  endproperty
  a_otp_burst: assert property (p_otp_burst) else $error("over-temperature tripped in burst mode");

  property p_idle;
    @(posedge clk) disable iff (!nrst)
      ($past(state_q) == lds_pkg::S_FAULT && state_q != lds_pkg::S_FAULT) |-> $past(idleCnt_q) == 25'(FAULT_IDLE_CYCLES - 1);
  endproperty
  a_idle: assert property (p_idle) else $error("fault left before idle time");

  property p_opt_hold;
    @(posedge clk) disable iff (!nrst) optLatched_q |=> optLatched_q && $stable(optIdx_q) && $stable(optInvalid_q);
  endproperty
  a_opt_hold: assert property (p_opt_hold) else $error("timing option changed after latch");

  property p_inhibit;
    @(posedge clk) disable iff (!nrst) (optLatched_q && optInvalid_q) |-> ##2 !switchEn;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("switching with invalid timing option");

  sequence s_copy_start;
    loFall && !hoFall && !hlEnd && slewSeen_q && !zcsSeen_q && !zcsEvent;
  endsequence
  property p_copy;
    @(posedge clk) disable iff (!nrst) s_copy_start |=> copyOk_q && lhActive_q && dtCnt_q == 8'h00;
  endproperty
  a_copy: assert property (p_copy) else $error("dead time not copied");

endmodule

//--- core/lds_pkg.sv
package lds_pkg;
  localparam int CLK_MHZ = 20;
  localparam int OVP_QUAL_US = 40;
  localparam int OVP_QUAL_CYC = OVP_QUAL_US * CLK_MHZ;
  localparam int FAULT_IDLE_S = 1;
  localparam int FAULT_IDLE_CYC = FAULT_IDLE_S * CLK_MHZ * 1000000;
  localparam int DT_SHORT_NS = 500;
  localparam int DT_LONG_NS = 1000;
  localparam logic [7:0] DT_SHORT_CYC = 8'((DT_SHORT_NS * CLK_MHZ) / 1000);
  localparam logic [7:0] DT_LONG_CYC = 8'((DT_LONG_NS * CLK_MHZ) / 1000);
  localparam int OPT_COUNT = 17;
  localparam logic [4:0] OPT_SHORT_DT_FIRST = 5'h0d;
  localparam logic [12:0] TIMING_SELECT_PIN_TOL_MV = 13'h0030;
  localparam logic [12:0] TIMING_SELECT_PIN_INVALID_LO_MV = 13'h0188;
  localparam logic [12:0] TIMING_SELECT_PIN_INVALID_HI_MV = 13'h11ed;
  // index 0 is option 1
  localparam logic [12:0] TIMING_SELECT_PIN_LO_BAND_MV [OPT_COUNT] = '{
    13'd450, 13'd547, 13'd644, 13'd742, 13'd850, 13'd967, 13'd1074, 13'd1182, 13'd1299,
    13'd1416, 13'd1533, 13'd1660, 13'd1787, 13'd1914, 13'd2041, 13'd2168, 13'd2295};
  localparam logic [12:0] TIMING_SELECT_PIN_HI_BAND_MV [OPT_COUNT] = '{
    13'd4532, 13'd4433, 13'd4336, 13'd4238, 13'd4130, 13'd4013, 13'd3906, 13'd3798, 13'd3681,
    13'd3554, 13'd3427, 13'd3310, 13'd3183, 13'd3056, 13'd2929, 13'd2802, 13'd2675};
  localparam logic [9:0] INT_TC_NS [OPT_COUNT] = '{
    10'd968, 10'd820, 10'd694, 10'd588, 10'd490, 10'd424, 10'd359, 10'd304, 10'd257,
    10'd214, 10'd184, 10'd156, 10'd132, 10'd112, 10'd93, 10'd80, 10'd68};
  localparam logic [12:0] MIN_FREQ_DKHZ [OPT_COUNT] = '{
    13'd489, 13'd577, 13'd681, 13'd805, 13'd950, 13'd1122, 13'd1325, 13'd1565, 13'd1848,
    13'd2182, 13'd2567, 13'd3043, 13'd3593, 13'd4243, 13'd5010, 13'd5916, 13'd6986};
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DEADTIME = 4'h8;
  localparam int CTRL_OVP_EN_BIT = 0;
  localparam int CTRL_RUN_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_CAUSE_LSB = 4;
  localparam int ST_OPT_LSB = 8;
  localparam int ST_INVALID_BIT = 13;
  localparam int ST_LATCHED_BIT = 14;
  typedef enum logic [2:0] {S_INIT, S_INHIBIT, S_BROWN, S_SOFT, S_RUN, S_FAULT, S_HOLD} lds_state_type;
  typedef enum logic [1:0] {C_NONE, C_INOVP, C_OUTOVP, C_OTP} lds_cause_type;
  typedef struct packed {
    logic fbLow;
    logic blkBelowStop;
    logic blkAboveBrownIn;
    logic blkAboveOvp;
    logic protAboveOvp;
    logic protBelowOtp;
    logic slewDone;
    logic ipolPos;
  } lds_cmp_type;
endpackage

//--- test/lds_stage_model.sv
`timescale 1ns/1ps
module lds_stage_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic switchEn,
  input wire logic loOnReq,
  input wire logic hoOnReq,
  input wire logic kick,
  input wire logic noSlew,
  input wire logic [7:0] slewDly,
  input wire logic [7:0] ipolDly,
  output logic hoFall,
  output logic loFall,
  output logic slewDone,
  output logic ipolPos
);
  logic [7:0] hoOn_q;
  logic [7:0] loOn_q;
  logic [7:0] sHo_q;
  logic [7:0] sLo_q;
  logic waitLo_q;
  ////////////////////////////////////////////////////////////////
  // each gate stays on 40 cycles, well past any dead time
  assign hoFall = (hoOn_q == 8'h01);
  assign loFall = (loOn_q == 8'h01);
  always_ff @(posedge clk)
  begin
    if (!nrst || !switchEn)
    begin
      hoOn_q <= 8'h00;
      loOn_q <= 8'h00;
      sHo_q <= 8'h00;
      sLo_q <= 8'h00;
      waitLo_q <= 1'b0;
      slewDone <= 1'b0;
      ipolPos <= 1'b0;
    end
    else
    begin
      hoOn_q <= (kick || hoOnReq) ? 8'h28 : hoOn_q - 8'((hoOn_q != 8'h00));
      loOn_q <= loOnReq ? 8'h28 : loOn_q - 8'((loOn_q != 8'h00));
      sHo_q <= hoFall ? 8'h00 : sHo_q + 8'((sHo_q != 8'hff));
      sLo_q <= loFall ? 8'h00 : sLo_q + 8'((sLo_q != 8'hff));
      waitLo_q <= hoFall || (waitLo_q && !loOnReq);
      // a slow switch node never trips the slew detector
      slewDone <= waitLo_q && !loOnReq && !noSlew && (sHo_q >= slewDly);
      // tank current reverses a fixed time after each gate turn-off
      ipolPos <= (sLo_q < sHo_q) ? (sLo_q >= ipolDly) : (sHo_q < ipolDly);
    end
  end
endmodule

//--- test/lds_supervisor_tb.sv
`timescale 1ns/1ps
module lds_supervisor_tb;
  localparam int IDLE = 50;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [12:0] tsetMv = 13'h0;
  logic tsetValid = 1'b0;
  logic ocpHighBand = 1'b0;
  lds_pkg::lds_cmp_type cmpTb = '0;
  lds_pkg::lds_cmp_type cmpIn;
  logic burstMode = 1'b0;
  logic zcsAction = 1'b0;
  logic slowSlew = 1'b0;
  logic zcsEvent = 1'b0;
  logic softStartReq;
  logic [12:0] minFreqDkhz;
  logic kick = 1'b0;
  logic noSlew = 1'b0;
  logic hoFall, loFall, mSlew, mIpol, switchEn, hysSinkEn, fbClampEn, loOnReq, hoOnReq;
  logic [9:0] intTcNs;
  logic [7:0] deadTimeMax;
  int miscompares = 0;
  int numChecks = 0;
  int tHo = 0;
  int tLo = 0;
  int dtHL = 0;
  int dtLH = 0;
  logic [31:0] d;
  int t;
  always #25 clk = ~clk;
  always_comb
  begin
    cmpIn = cmpTb;
    cmpIn.slewDone = mSlew;
    cmpIn.ipolPos = mIpol;
  end
  lds_supervisor #(.FAULT_IDLE_CYCLES(IDLE)) uut (.clk(clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .tsetMv(tsetMv),
    .tsetValid(tsetValid), .ocpHighBand(ocpHighBand), .cmpIn(cmpIn), .burstMode(burstMode),
    .zcsAction(zcsAction), .zcsEvent(zcsEvent), .slowSlew(slowSlew), .hoFall(hoFall), .loFall(loFall),
    .softStartDone(1'b1), .switchEn(switchEn), .softStartReq(softStartReq), .hysSinkEn(hysSinkEn),
    .fbClampEn(fbClampEn), .loOnReq(loOnReq), .hoOnReq(hoOnReq), .intTcNs(intTcNs), .minFreqDkhz(minFreqDkhz),
    .deadTimeMax(deadTimeMax));
  lds_stage_model stage (.clk(clk), .nrst(nrst), .switchEn(switchEn), .loOnReq(loOnReq),
    .hoOnReq(hoOnReq), .kick(kick), .noSlew(noSlew), .slewDly(8'h05), .ipolDly(8'h0c), .hoFall(hoFall),
    .loFall(loFall), .slewDone(mSlew), .ipolPos(mIpol));
  ////////////////////////////////////////////////////////////////
  // dead times measured at the falling edge, where everything has settled
  always @(negedge clk)
  begin
    tHo = hoFall ? 0 : tHo + 1;
    tLo = loFall ? 0 : tLo + 1;
    if (loOnReq) dtHL = tHo;
    if (hoOnReq) dtLH = tLo;
  end
  task automatic close_out;
    if (miscompares == 0 && numChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    // only the watchdog ends a wait that never sees waitrequest low
    do
      @(posedge clk);
    while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wait_sw(input logic v, input int lim);
    t = 0;
    while (switchEn !== v && t < lim)
    begin
      @(posedge clk);
      t++;
    end
  endtask
  task automatic go_run(input logic [12:0] mv, input logic band);
    @(posedge clk);
    nrst <= 1'b0;
    // input sense above brown-in, every other comparator quiet
    cmpTb <= 8'h20;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    tsetMv <= mv;
    ocpHighBand <= band;
    tsetValid <= 1'b1;
    @(posedge clk);
    tsetValid <= 1'b0;
    wait_sw(1'b1, 30);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    bus(1'b0, lds_pkg::REG_CTRL, 32'h0, d);
    chk(d, 32'h3);
    bus(1'b0, 4'hc, 32'h0, d);
    chk(d, 32'h0);
    bus(1'b1, lds_pkg::REG_STATUS, 32'hffffffff, d);
    bus(1'b0, lds_pkg::REG_STATUS, 32'h0, d);
    chk(32'(d[2:0]), 32'h0);
  endtask
  task automatic t_options;
    for (int i = 0; i < 17; i++)
    begin
      // odd options use the upper band, even ones sit on the tolerance edge
      go_run(i % 2 ? lds_pkg::TIMING_SELECT_PIN_HI_BAND_MV[i] : lds_pkg::TIMING_SELECT_PIN_LO_BAND_MV[i] + 13'h0030, 1'(i % 2));
      bus(1'b0, lds_pkg::REG_STATUS, 32'h0, d);
      chk(32'(d[12:8]), 32'(i));
      chk(32'(deadTimeMax), i >= 13 ? 32'ha : 32'h14);
      chk(32'(switchEn), 32'h1);
      if (i == 0) chk(32'(intTcNs), 32'd968);
      if (i == 16) chk(32'(intTcNs), 32'd68);
      if (i == 0) chk(32'(minFreqDkhz), 32'd489);
      if (i == 16) chk(32'(minFreqDkhz), 32'd6986);
    end
    go_run(13'h0187, 1'b0);
    bus(1'b0, lds_pkg::REG_STATUS, 32'h0, d);
    chk(32'(d[13]), 32'h1);
    go_run(13'h11ee, 1'b1);
    chk(32'(switchEn), 32'h0);
  endtask
  task automatic t_latch_clamp;
    go_run(13'd2295, 1'b0);
    tsetMv <= 13'd450;
    tsetValid <= 1'b1;
    @(posedge clk);
    tsetValid <= 1'b0;
    cmpTb.fbLow <= 1'b1;
    cyc(5);
    chk(32'(intTcNs), 32'd68);
    chk(32'(fbClampEn), 32'h1);
    cmpTb.fbLow <= 1'b0;
    cyc(5);
    chk(32'(fbClampEn), 32'h0);
  endtask
  task automatic t_brown_inovp;
    cmpTb <= 8'h40;
    wait_sw(1'b0, 8);
    cyc(2);
    chk(32'(hysSinkEn), 32'h1);
    cmpTb <= 8'h20;
    wait_sw(1'b1, 10);
    chk(32'(softStartReq), 32'h1);
    chk(32'(t < 10), 32'h1);
    cmpTb.blkAboveOvp <= 1'b1;
    wait_sw(1'b0, 8);
    bus(1'b0, lds_pkg::REG_STATUS, 32'h0, d);
    chk(32'(d[5:4]), 32'h1);
    cyc(IDLE + 20);
    chk(32'(switchEn), 32'h0);
    cmpTb.blkAboveOvp <= 1'b0;
    wait_sw(1'b1, 12);
    chk(32'(t < 12), 32'h1);
    bus(1'b1, lds_pkg::REG_CTRL, 32'h2, d);
    bus(1'b0, lds_pkg::REG_CTRL, 32'h0, d);
    chk(d, 32'h2);
    cmpTb.blkAboveOvp <= 1'b1;
    cyc(10);
    chk(32'(switchEn), 32'h1);
    cmpTb.blkAboveOvp <= 1'b0;
    bus(1'b1, lds_pkg::REG_CTRL, 32'h3, d);
  endtask
  task automatic t_outovp_otp;
    cmpTb.protAboveOvp <= 1'b1;
    cyc(790);
    cmpTb.protAboveOvp <= 1'b0;
    cyc(10);
    chk(32'(switchEn), 32'h1);
    cmpTb.protAboveOvp <= 1'b1;
    wait_sw(1'b0, 830);
    chk(32'(t >= 798 && t <= 812), 32'h1);
    cmpTb.protAboveOvp <= 1'b0;
    wait_sw(1'b1, IDLE + 30);
    chk(32'(t >= IDLE - 5 && t <= IDLE + 10), 32'h1);
    burstMode <= 1'b1;
    cmpTb.protBelowOtp <= 1'b1;
    cyc(20);
    chk(32'(switchEn), 32'h1);
    burstMode <= 1'b0;
    wait_sw(1'b0, 8);
    chk(32'(t < 8), 32'h1);
    cmpTb.protBelowOtp <= 1'b0;
    cyc(IDLE + 20);
    bus(1'b0, lds_pkg::REG_STATUS, 32'h0, d);
    chk({28'h0, switchEn, d[2:0]}, 32'h6);
    cmpTb.protAboveOvp <= 1'b1;
    wait_sw(1'b1, 10);
    chk(32'(t < 10), 32'h1);
    cmpTb.protAboveOvp <= 1'b0;
  endtask
  task automatic t_deadtime;
    go_run(13'd450, 1'b0);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    cyc(300);
    chk(32'(dtHL >= 5 && dtHL <= 15), 32'h1);
    chk(32'(dtLH >= dtHL - 1 && dtLH <= dtHL + 1), 32'h1);
    noSlew <= 1'b1;
    cyc(300);
    chk(32'(dtHL >= 19 && dtHL <= 21), 32'h1);
    chk(32'(dtLH >= 12 && dtLH <= 18), 32'h1);
    for (int k = 0; k < 3; k++)
    begin
      burstMode <= (k == 0);
      zcsAction <= (k == 1);
      slowSlew <= (k == 2);
      cyc(300);
      chk(32'(dtHL >= 12 && dtHL <= 18), 32'h1);
    end
    slowSlew <= 1'b0;
    noSlew <= 1'b0;
    cyc(300);
    // a zero-current event inside the low half cycle blocks the next copy
    wait (loOnReq === 1'b1);
    @(posedge clk);
    zcsEvent <= 1'b1;
    @(posedge clk);
    zcsEvent <= 1'b0;
    wait (hoOnReq === 1'b1);
    @(posedge clk);
    chk(32'(dtLH >= 12 && dtLH <= 18), 32'h1);
  endtask
  initial
  begin
    #2000000;
    miscompares++;
    close_out();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_options();
    t_latch_clamp();
    t_brown_inovp();
    t_outovp_otp();
    t_deadtime();
    close_out();
  end
endmodule
